/* File: pkg/mal_pkg.sv */
// Package for the mic AGC ceiling and debounce block.
// Assumes a 50 MHz clock and APB with 32-bit data.
package mal_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] HS_LIM_IDX = 8'h26;
  localparam logic [7:0] CELL_LIM_IDX = 8'h27;
  localparam logic [7:0] SETUP_IDX = 8'h28;
  localparam logic [7:0] STAT_IDX = 8'h29;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  // Field positions
  localparam int CEIL_LSB = 9;
  localparam int TOSIL_LSB = 6;
  localparam int TONRM_LSB = 3;
  localparam int THR_LSB = 11;
  localparam int EN_BIT = 0;
  localparam int STAT_HSSIL = 0;
  localparam int STAT_CSIL = 1;
  localparam int STAT_HSG_LSB = 8;
  localparam int STAT_CG_LSB = 16;
  // Reset values
  localparam logic [6:0] CEIL_RST = 7'h7F;
  localparam logic [2:0] DEB_RST = 3'h0;
  localparam logic [2:0] THR_RST = 3'h0;
  // Cell ceiling codes from here up mean 12 dB
  localparam logic [6:0] CELL_12DB_MIN = 7'h5E;
  localparam logic [6:0] CELL_12DB_CODE = 7'h5D;
  // Noise threshold in dB below full scale
  localparam logic [7:0] THR_BASE_DB = 8'h1E;
  localparam logic [7:0] THR_STEP_DB = 8'h0A;
  // Debounce timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int DEB_BASE_NS = 500000;
  localparam int DEB_BASE_CYC = DEB_BASE_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 22;

  // Fields of one limit register
  typedef struct packed {
    logic [6:0] ceil;
    logic [2:0] to_sil;
    logic [2:0] to_nrm;
  } mal_lim_t;

  // One debounce path
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic sil;
  } mal_deb_t;
endpackage

/* File: hdl/mal_agc_limit.sv */
// Mic AGC gain ceilings and silence debounce, APB slave.
// Assumes level and gain request inputs come from AGC logic
// on clk_i; one access phase cycle per APB transfer.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module mal_agc_limit
  import mal_pkg::*;
#(
  parameter int DEB_BASE = DEB_BASE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [7:0] hs_level_i,
  input wire logic [7:0] cell_level_i,
  input wire logic [6:0] hs_gain_req_i,
  input wire logic [6:0] cell_gain_req_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [6:0] hs_gain_o,
  output logic [6:0] cell_gain_o,
  output logic hs_silence_o,
  output logic cell_silence_o
);

  typedef struct packed {
    mal_lim_t hs;
    logic [6:0] cell_ceil;
    logic [2:0] thr;
    logic cell_en;
    mal_deb_t hs_d;
    mal_deb_t cell_d;
    logic [6:0] hs_g;
    logic [6:0] cell_g;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } mal_state_t;

  mal_state_t s_r;
  mal_state_t s_nxt;

  // Debounce length in cycles for a 3-bit code
  function automatic logic [CNT_W-1:0] deb_lim(input logic [2:0] c);
    logic [CNT_W-1:0] b;
    b = CNT_W'(DEB_BASE);
    deb_lim = (c == 3'h0) ? '0 : (b << (c - 3'h1));
  endfunction

  // Threshold code to dB below full scale
  function automatic logic [7:0] thr_db(input logic [2:0] c);
    thr_db = THR_BASE_DB;
    if (c > 3'h1) begin
      thr_db = THR_BASE_DB + THR_STEP_DB * 8'(c - 3'h1);
    end
  endfunction

  // One debounce step of a silence/normal path
  function automatic mal_deb_t deb_step(input mal_deb_t d,
      input logic below, input logic [2:0] to_sil,
      input logic [2:0] to_nrm);
    logic cond;
    logic [CNT_W-1:0] lim;
    deb_step = d;
    cond = d.sil ? !below : below;
    lim = d.sil ? deb_lim(to_nrm) : deb_lim(to_sil);
    if (!cond) begin
      deb_step.cnt = '0;
    end else if (lim == '0 || d.cnt + 1'b1 >= lim) begin
      deb_step.sil = !d.sil;
      deb_step.cnt = '0;
    end else begin
      deb_step.cnt = d.cnt + 1'b1;
    end
  endfunction

  logic [7:0] idx;
  logic hs_below;
  logic cell_below;
  logic [6:0] cell_eff;
  logic [2:0] cell_sil_code;
  logic [2:0] cell_nrm_code;

  // Decode, level compare and effective cell ceiling
  always_comb begin
    idx = paddr_i[IDX_LSB +: 8];
    hs_below = hs_level_i > thr_db(s_r.thr);
    cell_below = cell_level_i > thr_db(s_r.thr);
    cell_sil_code = DEB_RST;
    cell_nrm_code = DEB_RST;
    cell_eff = s_r.cell_ceil;
    if (s_r.cell_ceil >= CELL_12DB_MIN) begin
      cell_eff = CELL_12DB_CODE;
    end
  end

  // Next state: registers, debounce and clamped gains
  always_comb begin
    s_nxt = s_r;
    s_nxt.ready = psel_i && !penable_i;
    s_nxt.err = 1'b0;
    if (psel_i && !penable_i) begin
      s_nxt.rdata = '0;
      unique case (idx)
        HS_LIM_IDX: begin
          s_nxt.rdata[CEIL_LSB +: 7] = s_r.hs.ceil;
          s_nxt.rdata[TOSIL_LSB +: 3] = s_r.hs.to_sil;
          s_nxt.rdata[TONRM_LSB +: 3] = s_r.hs.to_nrm;
        end
        CELL_LIM_IDX: begin
          s_nxt.rdata[CEIL_LSB +: 7] = s_r.cell_ceil;
          s_nxt.rdata[TOSIL_LSB +: 3] = cell_sil_code;
          s_nxt.rdata[TONRM_LSB +: 3] = cell_nrm_code;
        end
        SETUP_IDX: begin
          s_nxt.rdata[THR_LSB +: 3] = s_r.thr;
          s_nxt.rdata[EN_BIT] = s_r.cell_en;
        end
        STAT_IDX: begin
          s_nxt.rdata[STAT_HSSIL] = s_r.hs_d.sil;
          s_nxt.rdata[STAT_CSIL] = s_r.cell_d.sil;
          s_nxt.rdata[STAT_HSG_LSB +: 7] = s_r.hs_g;
          s_nxt.rdata[STAT_CG_LSB +: 7] = s_r.cell_g;
        end
        default: begin
          s_nxt.err = 1'b1; // Unmapped address
        end
      endcase
    end
    // Write takes effect at the access edge
    if (psel_i && penable_i && s_r.ready && pwrite_i) begin
      unique case (idx)
        HS_LIM_IDX: begin
          s_nxt.hs.ceil = pwdata_i[CEIL_LSB +: 7];
          s_nxt.hs.to_sil = pwdata_i[TOSIL_LSB +: 3];
          s_nxt.hs.to_nrm = pwdata_i[TONRM_LSB +: 3];
        end
        CELL_LIM_IDX: begin
          s_nxt.cell_ceil = pwdata_i[CEIL_LSB +: 7];
        end
        SETUP_IDX: begin
          s_nxt.thr = pwdata_i[THR_LSB +: 3];
          s_nxt.cell_en = pwdata_i[EN_BIT];
        end
        default: begin
          s_nxt.err = 1'b0; // Read-only or unmapped
        end
      endcase
    end
    s_nxt.hs_d = deb_step(s_r.hs_d, hs_below, s_r.hs.to_sil, s_r.hs.to_nrm);
    s_nxt.hs_g = (hs_gain_req_i > s_r.hs.ceil) ? s_r.hs.ceil : hs_gain_req_i;
    if (s_r.cell_en) begin
      s_nxt.cell_d = deb_step(s_r.cell_d, cell_below, cell_sil_code, cell_nrm_code);
      s_nxt.cell_g = (cell_gain_req_i > cell_eff) ? cell_eff : cell_gain_req_i;
    end else begin
      s_nxt.cell_d = '0;
      s_nxt.cell_g = cell_gain_req_i;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
      s_r.hs.ceil <= CEIL_RST;
      s_r.hs.to_sil <= DEB_RST;
      s_r.hs.to_nrm <= DEB_RST;
      s_r.cell_ceil <= CEIL_RST;
      s_r.thr <= THR_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign prdata_o = s_r.rdata;
  assign pready_o = s_r.ready;
  assign pslverr_o = s_r.err;
  assign hs_gain_o = s_r.hs_g;
  assign cell_gain_o = s_r.cell_g;
  assign hs_silence_o = s_r.hs_d.sil;
  assign cell_silence_o = s_r.cell_d.sil;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_wr_hs;
    psel_i && penable_i && pready_o && pwrite_i && idx == HS_LIM_IDX;
  endsequence

  sequence s_hs_entry;
    !hs_silence_o && hs_below && s_r.hs.to_sil == 3'h0;
  endsequence

  // Register write and read strobes of the checks below
  sequence s_wr_setup;
    psel_i && penable_i && pready_o && pwrite_i && idx == SETUP_IDX;
  endsequence

  sequence s_rd_lim;
    psel_i && !penable_i && (idx == HS_LIM_IDX || idx == CELL_LIM_IDX);
  endsequence

  // Cell path conditions that must switch at once
  sequence s_cell_entry;
    s_r.cell_en && !cell_silence_o && cell_below;
  endsequence

  sequence s_cell_exit;
    s_r.cell_en && cell_silence_o && !cell_below;
  endsequence

  chk_hs_write: assert property (s_wr_hs |=>
    s_r.hs.ceil == $past(pwdata_i[CEIL_LSB +: 7]))
    else $error("headset ceiling not written");

  chk_hs_clamp: assert property (hs_gain_o <= $past(s_r.hs.ceil))
    else $error("headset gain above ceiling");

  chk_hs_zero_deb: assert property (s_hs_entry |=> hs_silence_o)
    else $error("zero debounce did not switch");

  chk_hs_to_sil: assert property ($rose(hs_silence_o) |->
    $past(hs_below) && ($past(s_r.hs_d.cnt) + 1'b1 >= deb_lim($past(s_r.hs.to_sil))))
    else $error("silence entered early");

  chk_hs_to_nrm: assert property ($fell(hs_silence_o) |->
    !$past(hs_below) && ($past(s_r.hs_d.cnt) + 1'b1 >= deb_lim($past(s_r.hs.to_nrm))))
    else $error("normal entered early");

  chk_deb_restart: assert property ((hs_silence_o == hs_below) |=> s_r.hs_d.cnt == '0)
    else $error("debounce count not restarted");

  chk_cell_12db: assert property (s_r.cell_en && s_r.cell_ceil >= CELL_12DB_MIN
    && cell_gain_req_i == CEIL_RST |=> cell_gain_o == CELL_12DB_CODE)
    else $error("cell ceiling not 12 dB");

  chk_cell_off: assert property (!s_r.cell_en |=>
    cell_gain_o == $past(cell_gain_req_i) && !cell_silence_o)
    else $error("cell AGC acted while off");

  chk_cell_deb_ro: assert property (psel_i && !penable_i && idx == CELL_LIM_IDX
    |=> prdata_o[TONRM_LSB +: 6] == 6'h00)
    else $error("cell debounce field not zero");

  chk_cell_ceil_wr: assert property (psel_i && penable_i && pready_o && pwrite_i
    && idx == CELL_LIM_IDX |=> s_r.cell_ceil == $past(pwdata_i[CEIL_LSB +: 7]))
    else $error("cell ceiling not written");

  // Debounce codes and shared setup land on the access edge
  chk_hs_sil_wr: assert property (s_wr_hs |=>
    s_r.hs.to_sil == $past(pwdata_i[TOSIL_LSB +: 3]))
    else $error("headset to-silence code not written");

  chk_hs_nrm_wr: assert property (s_wr_hs |=>
    s_r.hs.to_nrm == $past(pwdata_i[TONRM_LSB +: 3]))
    else $error("headset to-normal code not written");

  chk_setup_wr: assert property (s_wr_setup |=>
    s_r.thr == $past(pwdata_i[THR_LSB +: 3]) && s_r.cell_en == $past(pwdata_i[EN_BIT]))
    else $error("setup register not written");

  // Reserved low bits of both limit registers read zero
  chk_rsv_zero: assert property (s_rd_lim |=>
    prdata_o[TONRM_LSB-1:0] == '0)
    else $error("reserved bits not zero");

  // Cell gain never above the effective ceiling while enabled
  chk_cell_clamp: assert property (s_r.cell_en |=>
    cell_gain_o <= $past(cell_eff))
    else $error("cell gain above ceiling");

  // Cell debounce codes read zero, so both changes are immediate
  chk_cell_enter: assert property (s_cell_entry |=> cell_silence_o)
    else $error("cell silence not entered");

  chk_cell_leave: assert property (s_cell_exit |=> !cell_silence_o)
    else $error("cell silence not left");

  // Both paths judge a level against the same threshold
  chk_thr_shared: assert property (hs_level_i == cell_level_i |->
    hs_below == cell_below)
    else $error("paths use different thresholds");

endmodule

/* File: tb/tb.sv */
// Self-checking testbench for the mic AGC ceiling and debounce block.
// Drives APB and the AGC level and gain inputs itself; DEB_BASE is shrunk to 4 cycles.
`timescale 1ns/1ps
module tb;
  import mal_pkg::*;
  localparam int DB = 4;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [7:0] hs_lvl = '0, cell_lvl = '0;
  logic [6:0] hs_req = '0, cell_req = '0;
  logic [31:0] prdata, rd_v;
  logic pready, pslverr, hs_sil, cell_sil, err_v;
  logic [6:0] hs_gain, cell_gain;
  logic [6:0] codes [6] = '{7'h00, 7'h44, 7'h5E, 7'h5F, 7'h60, 7'h7F};
  int mismatches = 0;
  int n_checks = 0;

  // Free-running 50 MHz clock
  always #10 clk_i = ~clk_i;

  mal_agc_limit #(.DEB_BASE(DB)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .hs_level_i(hs_lvl), .cell_level_i(cell_lvl),
    .hs_gain_req_i(hs_req), .cell_gain_req_i(cell_req), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .hs_gain_o(hs_gain), .cell_gain_o(cell_gain),
    .hs_silence_o(hs_sil), .cell_silence_o(cell_sil)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Compares and counts; reports at once on a mismatch
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer; entered and left at a rising edge, request held until pready
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, idx, 32'h0);
    check(rd_v, exp);
    check({31'h0, err_v}, {31'h0, exp_err});
  endtask

  // Drives both gain requests and compares both limited gains
  task automatic gchk(input logic [6:0] hr, input logic [6:0] cr, input logic [6:0] he, input logic [6:0] ce);
    hs_req <= hr;
    cell_req <= cr;
    cyc(2);
    #1;
    check({25'h0, hs_gain}, {25'h0, he});
    check({25'h0, cell_gain}, {25'h0, ce});
    @(posedge clk_i);
  endtask

  // Silence output must hold for l-1 edges and change on the l-th
  task automatic flip(input logic hs, input int l, input logic exp);
    cyc(l - 1);
    #1;
    check({31'h0, hs ? hs_sil : cell_sil}, {31'h0, ~exp});
    @(posedge clk_i);
    #1;
    check({31'h0, hs ? hs_sil : cell_sil}, {31'h0, exp});
    @(posedge clk_i);
  endtask

  function automatic logic [6:0] cmin(input logic [6:0] a, input logic [6:0] b);
    return (a < b) ? a : b;
  endfunction

  // Watchdog against a hung handshake
  initial begin
    cyc(5000);
    mismatches++;
    finish_test();
  end

  // Main sequence
  initial begin
    cyc(4);
    rst_n_i <= 1'b1;
    cyc(1);
    rd(HS_LIM_IDX, 32'h0000FE00, 1'b0);
    rd(CELL_LIM_IDX, 32'h0000FE00, 1'b0);
    apb(1'b1, HS_LIM_IDX, 32'h0000FFF8);
    rd(HS_LIM_IDX, 32'h0000FFF8, 1'b0);
    apb(1'b1, CELL_LIM_IDX, 32'h0000FFF8);
    rd(CELL_LIM_IDX, 32'h0000FE00, 1'b0);
    rd(8'h30, 32'h0, 1'b1);
    // Headset ceiling sweep with cell loop still disabled
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, HS_LIM_IDX, {16'h0, codes[i], 9'h0});
      gchk(7'h7F, 7'h7F, codes[i], 7'h7F);
      gchk(7'h20, 7'h20, cmin(codes[i], 7'h20), 7'h20);
    end
    // Cell ceiling sweep with the loop enabled
    apb(1'b1, SETUP_IDX, 32'h00000001);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, CELL_LIM_IDX, {16'h0, codes[i], 9'h0});
      gchk(7'h7F, 7'h7F, 7'h7F, (codes[i] >= 7'h5E) ? 7'h5D : codes[i]);
      gchk(7'h20, 7'h20, 7'h20, cmin(codes[i], 7'h20));
    end
    // Debounce: to-silence code 1, to-normal code 2, threshold code 3
    apb(1'b1, HS_LIM_IDX, 32'h0000FE50);
    apb(1'b1, SETUP_IDX, 32'h00001801);
    hs_lvl <= 8'd50;
    cell_lvl <= 8'd50;
    cyc(12);
    #1;
    check({31'h0, hs_sil}, 32'h0);
    check({31'h0, cell_sil}, 32'h0);
    @(posedge clk_i);
    hs_lvl <= 8'd60;
    cyc(DB - 1);
    hs_lvl <= 8'd45;
    cyc(2 * DB);
    #1;
    check({31'h0, hs_sil}, 32'h0);
    @(posedge clk_i);
    hs_lvl <= 8'd60;
    flip(1'b1, DB, 1'b1);
    hs_lvl <= 8'd45;
    flip(1'b1, 2 * DB, 1'b0);
    cell_lvl <= 8'd60;
    flip(1'b0, 1, 1'b1);
    cell_lvl <= 8'd50;
    flip(1'b0, 1, 1'b0);
    cell_lvl <= 8'd60;
    flip(1'b0, 1, 1'b1);
    apb(1'b1, SETUP_IDX, 32'h00001800);
    cyc(2);
    #1;
    check({31'h0, cell_sil}, 32'h0);
    @(posedge clk_i);
    // Headset to-silence code 0 switches on the first quiet edge
    apb(1'b1, HS_LIM_IDX, 32'h0000FE00);
    hs_lvl <= 8'd60;
    flip(1'b1, 1, 1'b1);
    rd(STAT_IDX, 32'h00202001, 1'b0);
    finish_test();
  end
endmodule
